// ===== bench/fpcc_ctrl_tb.sv
// Purpose: self-checking bench for fpcc_ctrl
// Assumes: 100 MHz clock, sense values modelled from vout_target_o
// Notes: passing codes kept low because every sweep step lasts about 3000 cycles
`timescale 1ns/10ps
module fpcc_ctrl_tb;
    // ------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------
    logic mclk_i = 1'b0, nrst_i = 1'b0, cal_start_i = 1'b0, voltage_mode_force_i = 1'b0;
    logic torch_pin_enable_i = 1'b0, high_current_select_i = 1'b0, ov_wr_i = 1'b0;
    logic vin_ge_vout_i = 1'b0, vin_below_vout_200_i = 1'b0;
    logic [1:0] mode_ctrl_i = 2'h0, outer_sink_cal_current_i = 2'h2;
    logic [2:0] led_sink_enables_i = 3'h0, center_sink_cal_current_i = 3'h5;
    logic [3:0] ov_wdata_i = 4'h0;
    logic [29:0] sink_sense_mv_i = 30'h0;
    logic [4:0] led_level_req_i = 5'h0;
    logic calibration_flag_o, cal_busy_o, test_strobe_o, power_stage_off_o, down_mode_o;
    logic ramp_tick_o;
    logic [3:0] output_voltage_code_o, vout_target_o;
    logic [1:0] strobe_outer_cur_o, worst_sink_o;
    logic [2:0] strobe_center_cur_o;
    logic [4:0] led_level_o;
    logic [20:0] led_current_ua_o;
    int miscompares = 0;
    int tests_run = 0;
    int sl1 = 100, of1 = 200, sl2 = 100, sl3 = 0;

    always #5 mclk_i = ~mclk_i;

    fpcc_ctrl #(.LVL_W(5)) dut (.mclk_i, .nrst_i, .cal_start_i, .mode_ctrl_i,
        .voltage_mode_force_i, .torch_pin_enable_i, .led_sink_enables_i,
        .outer_sink_cal_current_i, .center_sink_cal_current_i, .high_current_select_i,
        .ov_wr_i, .ov_wdata_i, .sink_sense_mv_i, .vin_ge_vout_i, .vin_below_vout_200_i,
        .led_level_req_i, .calibration_flag_o, .cal_busy_o, .output_voltage_code_o,
        .vout_target_o, .test_strobe_o, .strobe_outer_cur_o, .strobe_center_cur_o,
        .power_stage_off_o, .worst_sink_o, .down_mode_o, .led_level_o, .led_current_ua_o,
        .ramp_tick_o);

    // ------------------------------------------------------------
    // sense model: headroom grows with the converter code
    // ------------------------------------------------------------
    function automatic logic [9:0] sns(input int b, input int s);
        int v;
        v = b + s * int'(vout_target_o);
        return (v > 1023) ? 10'h3ff : 10'(v);
    endfunction
    always @(posedge mclk_i) sink_sense_mv_i <= {sns(0, sl3), sns(0, sl2), sns(of1, sl1)};

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic host_wr(input logic [3:0] d);
        @(posedge mclk_i);
        ov_wr_i <= 1'b1;
        ov_wdata_i <= d;
        @(posedge mclk_i);
        ov_wr_i <= 1'b0;
        @(posedge mclk_i);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic run_cal(input logic hc, input logic [2:0] en, input int ec, input int ew);
        int n;
        logic pv;
        n = 0;
        pv = 1'b0;
        @(posedge mclk_i);
        high_current_select_i <= hc;
        led_sink_enables_i <= en;
        cal_start_i <= 1'b1;
        @(posedge mclk_i);
        cal_start_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk("flag_clear", 0, calibration_flag_o);
        chk("busy", 1, cal_busy_o);
        chk("start_code", 0, vout_target_o);
        for (int i = 0; i < 60000 && calibration_flag_o !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
            if (test_strobe_o === 1'b1 && pv !== 1'b1) begin
                chk("step_code", n, vout_target_o);
                chk("cal_cur", 5'h15, {strobe_outer_cur_o, strobe_center_cur_o});
                chk("stage_off", hc, power_stage_off_o);
                n++;
            end
            pv = test_strobe_o;
        end
        if (calibration_flag_o !== 1'b1) begin
            miscompares++;
            give_verdict;
        end
        chk("steps", ec + 1, n);
        chk("result", ec, output_voltage_code_o);
        chk("worst", ew, worst_sink_o);
        chk("strobe_idle", 0, {test_strobe_o, strobe_outer_cur_o, power_stage_off_o});
    endtask

    task automatic t_host;
        host_wr(4'h9);
        chk("target", 9, vout_target_o);
        chk("result_kept", 3, output_voltage_code_o);
        @(posedge mclk_i);
        vin_ge_vout_i <= 1'b1;
        host_wr(4'h5);
        chk("no_lower", 9, vout_target_o);
        host_wr(4'hc);
        chk("raise", 12, vout_target_o);
    endtask

    task automatic t_down;
        chk("no_down", 0, down_mode_o);
        @(posedge mclk_i);
        mode_ctrl_i <= 2'h3;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("down_on", 1, down_mode_o);
        @(posedge mclk_i);
        vin_ge_vout_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("down_hold", 1, down_mode_o);
        @(posedge mclk_i);
        vin_below_vout_200_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("down_off", 0, down_mode_o);
        @(posedge mclk_i);
        mode_ctrl_i <= 2'h0;
        vin_below_vout_200_i <= 1'b0;
        voltage_mode_force_i <= 1'b1;
        vin_ge_vout_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("down_forced", 1, down_mode_o);
        @(posedge mclk_i);
        voltage_mode_force_i <= 1'b0;
        vin_ge_vout_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("down_released", 0, down_mode_o);
    endtask

    // each step lands exactly on the ramp period and raises one tick
    task automatic ramp(input logic hc, input logic [4:0] req, input int st, input int per,
        input int ua);
        int c;
        int t;
        c = 0;
        t = 0;
        @(posedge mclk_i);
        high_current_select_i <= hc;
        led_level_req_i <= req;
        #1;
        while (led_level_o !== req && c < 10000) begin
            @(posedge mclk_i);
            #1;
            c++;
            if (ramp_tick_o === 1'b1) t++;
        end
        chk("level", req, led_level_o);
        chk("ramp_time", st * per, c);
        chk("ticks", st, t);
        repeat (2) @(posedge mclk_i);
        #1;
        chk("current", req * ua, led_current_ua_o);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        chk("reset", 0, {calibration_flag_o, cal_busy_o, vout_target_o, down_mode_o});
        run_cal(1'b0, 3'b011, 4, 1);
        sl2 = 0;
        sl3 = 150;
        run_cal(1'b1, 3'b101, 3, 2);
        t_host;
        t_down;
        run_cal(1'b0, 3'b010, 15, 1);
        ramp(1'b0, 5'h2, 2, 1200, 25000);
        ramp(1'b1, 5'h6, 4, 50, 56250);
        ramp(1'b1, 5'h1, 5, 50, 56250);
        ramp(1'b0, 5'h0, 1, 50, 25000);
        give_verdict;
    end
endmodule // fpcc_ctrl_tb

// ===== rtl/fpcc_ctrl.sv
// Purpose: precharge self-calibration, led current ramp, down-mode control
// Assumes: analog comparators and sense values arrive as synchronous inputs
// Notes: one clock, synchronous active-low reset
`timescale 1ns/10ps
module fpcc_ctrl #(
    parameter int LVL_W = 5
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic cal_start_i,
    input wire logic [1:0] mode_ctrl_i,
    input wire logic voltage_mode_force_i,
    input wire logic torch_pin_enable_i,
    input wire logic [2:0] led_sink_enables_i,
    input wire logic [1:0] outer_sink_cal_current_i,
    input wire logic [2:0] center_sink_cal_current_i,
    input wire logic high_current_select_i,
    input wire logic ov_wr_i,
    input wire logic [3:0] ov_wdata_i,
    input wire logic [29:0] sink_sense_mv_i,
    input wire logic vin_ge_vout_i,
    input wire logic vin_below_vout_200_i,
    input wire logic [LVL_W-1:0] led_level_req_i,
    output logic calibration_flag_o,
    output logic cal_busy_o,
    output logic [3:0] output_voltage_code_o,
    output logic [3:0] vout_target_o,
    output logic test_strobe_o,
    output logic [1:0] strobe_outer_cur_o,
    output logic [2:0] strobe_center_cur_o,
    output logic power_stage_off_o,
    output logic [1:0] worst_sink_o,
    output logic down_mode_o,
    output logic [LVL_W-1:0] led_level_o,
    output logic [20:0] led_current_ua_o,
    output logic ramp_tick_o
);
    localparam int TMR_W = fpcc_pkg::TMR_W;

    // ------------------------------------------------------------
    // calibration sequencer
    // ------------------------------------------------------------
    fpcc_pkg::fpcc_cal_e st_r, st_nxt;
    logic [TMR_W-1:0] tmr_r;
    logic [3:0] cal_code_r, host_ov_r, vout_r;
    logic flag_r, strobe_r, pstage_off_r;
    logic [1:0] worst_r;
    logic down_r;
    logic [LVL_W-1:0] lvl_r;
    logic [TMR_W-1:0] rtmr_r;
    logic tick_r;
    logic [20:0] cur_r;
    logic busy_r;
    logic [1:0] outer_r;
    logic [2:0] center_r;
    logic [3:0] ovc_r;
    logic [TMR_W-1:0] strb_len_r;

    wire logic [9:0] s0 = sink_sense_mv_i[9:0];
    wire logic [9:0] s1 = sink_sense_mv_i[19:10];
    wire logic [9:0] s2 = sink_sense_mv_i[29:20];
    // worst sink has the largest forward voltage, i.e. the lowest sense voltage
    wire logic [9:0] m0 = led_sink_enables_i[0] ? s0 : 10'h3ff; // RULE_03
    wire logic [9:0] m1 = led_sink_enables_i[1] ? s1 : 10'h3ff; // RULE_03
    wire logic [9:0] m2 = led_sink_enables_i[2] ? s2 : 10'h3ff; // RULE_03
    wire logic [1:0] w01 = (m1 < m0) ? 2'h1 : 2'h0;
    wire logic [9:0] v01 = (m1 < m0) ? m1 : m0;
    wire logic [1:0] worst_idx = (m2 < v01) ? 2'h2 : w01;
    wire logic [9:0] worst_mv = (m2 < v01) ? m2 : v01;
    wire logic all_ok = worst_mv >= fpcc_pkg::HEADROOM_MV; // RULE_06
    wire logic settle_done = tmr_r == TMR_W'(fpcc_pkg::SETTLE_CYC - 1);
    wire logic strobe_done = tmr_r == TMR_W'(fpcc_pkg::STROBE_CYC - 1);
    // an enabled but open sink never gains headroom; the sweep still ends at the top code
    wire logic at_top = cal_code_r == fpcc_pkg::OV_MAX; // RULE_17
    wire logic busy = st_r != fpcc_pkg::FPCC_IDLE;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            fpcc_pkg::FPCC_IDLE: if (cal_start_i) st_nxt = fpcc_pkg::FPCC_SETTLE; // RULE_01
            fpcc_pkg::FPCC_SETTLE: if (settle_done) st_nxt = fpcc_pkg::FPCC_STROBE;
            fpcc_pkg::FPCC_STROBE: if (strobe_done) st_nxt = fpcc_pkg::FPCC_EVAL; // RULE_19
            fpcc_pkg::FPCC_EVAL: begin
                if (all_ok || at_top) begin
                    st_nxt = fpcc_pkg::FPCC_IDLE; // RULE_06
                end else begin
                    st_nxt = fpcc_pkg::FPCC_SETTLE;
                end
            end
            default: st_nxt = fpcc_pkg::FPCC_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st_r <= fpcc_pkg::FPCC_IDLE;
            tmr_r <= '0;
            busy_r <= 1'b0;
        end else begin
            st_r <= cal_start_i ? fpcc_pkg::FPCC_SETTLE : st_nxt; // restart allowed
            busy_r <= cal_start_i || st_nxt != fpcc_pkg::FPCC_IDLE;
            tmr_r <= (st_nxt != st_r || cal_start_i) ? '0 : tmr_r + 1'b1;
        end
    end

    // a start wins over completion in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cal_code_r <= fpcc_pkg::OV_RST;
            flag_r <= 1'b0;
            worst_r <= 2'h0;
        end else if (cal_start_i) begin
            cal_code_r <= fpcc_pkg::OV_MIN; // RULE_02
            flag_r <= 1'b0; // RULE_08
        end else if (st_r == fpcc_pkg::FPCC_EVAL) begin
            worst_r <= worst_idx; // RULE_03
            if (all_ok || at_top) begin
                flag_r <= 1'b1; // RULE_07
            end else begin
                cal_code_r <= cal_code_r + 4'h1; // RULE_19
            end
        end
    end

    // strobe with calibration currents; high current keeps the inductor stage off
    wire logic strobe_go = st_nxt == fpcc_pkg::FPCC_STROBE && !cal_start_i;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            strobe_r <= 1'b0;
            pstage_off_r <= 1'b0;
            outer_r <= 2'h0;
            center_r <= 3'h0;
        end else begin
            strobe_r <= strobe_go; // RULE_04
            pstage_off_r <= strobe_go && high_current_select_i; // RULE_05
            outer_r <= strobe_go ? outer_sink_cal_current_i : 2'h0; // RULE_04
            center_r <= strobe_go ? center_sink_cal_current_i : 3'h0; // RULE_04
        end
    end

    // ------------------------------------------------------------
    // output voltage code and converter target
    // ------------------------------------------------------------
    wire logic [3:0] req_code = busy ? cal_code_r : host_ov_r;
    wire logic vreg = mode_ctrl_i == fpcc_pkg::MODE_VREG || voltage_mode_force_i;
    // reverse transfer cannot pull the output below the input supply
    wire logic hold_down = req_code < vout_r && vin_ge_vout_i; // RULE_13

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            host_ov_r <= fpcc_pkg::OV_RST;
            vout_r <= fpcc_pkg::OV_RST;
            down_r <= 1'b0;
        end else begin
            if (ov_wr_i) begin
                host_ov_r <= ov_wdata_i; // RULE_09
            end
            if (!hold_down) begin
                vout_r <= req_code; // RULE_02
            end
            if (!vreg) begin
                down_r <= 1'b0;
            end else if (vin_ge_vout_i) begin
                down_r <= 1'b1; // RULE_10
            end else if (vin_below_vout_200_i) begin
                down_r <= 1'b0; // RULE_11
            end
        end
    end

    // read-back is registered from next values so it lines up with the flag
    wire logic cal_fin = st_r == fpcc_pkg::FPCC_EVAL && (all_ok || at_top);
    wire logic flag_nxt = !cal_start_i && (cal_fin || flag_r);
    wire logic [3:0] cal_code_nxt = cal_start_i ? fpcc_pkg::OV_MIN
        : (st_r == fpcc_pkg::FPCC_EVAL && !cal_fin) ? cal_code_r + 4'h1 : cal_code_r;
    wire logic [3:0] vout_nxt = hold_down ? vout_r : req_code;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ovc_r <= fpcc_pkg::OV_RST;
        end else begin
            ovc_r <= flag_nxt ? cal_code_nxt : vout_nxt; // RULE_08
        end
    end

    // ------------------------------------------------------------
    // led current ramp
    // ------------------------------------------------------------
    wire logic ramp_up = led_level_req_i > lvl_r;
    wire logic ramp_dn = led_level_req_i < lvl_r;
    wire logic [TMR_W-1:0] up_per = high_current_select_i
        ? TMR_W'(fpcc_pkg::RAMP_UP_HC_CYC) : TMR_W'(fpcc_pkg::RAMP_UP_DD_CYC); // RULE_14
    wire logic [TMR_W-1:0] per = ramp_up ? up_per : TMR_W'(fpcc_pkg::RAMP_DN_CYC); // RULE_15
    wire logic step_now = (ramp_up || ramp_dn) && rtmr_r >= per - 1'b1;
    wire logic [15:0] step_ua = high_current_select_i ? fpcc_pkg::STEP_HC_UA
        : fpcc_pkg::STEP_DD_UA; // RULE_16

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            lvl_r <= '0;
            rtmr_r <= '0;
            tick_r <= 1'b0;
            cur_r <= '0;
        end else begin
            rtmr_r <= (step_now || !(ramp_up || ramp_dn)) ? '0 : rtmr_r + 1'b1;
            tick_r <= step_now;
            if (step_now) begin
                lvl_r <= ramp_up ? lvl_r + 1'b1 : lvl_r - 1'b1; // RULE_14 RULE_15
            end
            cur_r <= 21'(lvl_r) * 21'(step_ua); // RULE_16
        end
    end

    assign calibration_flag_o = flag_r;
    assign cal_busy_o = busy_r;
    // while the flag is set the code reads back the calibration result
    assign output_voltage_code_o = ovc_r; // RULE_08
    assign vout_target_o = vout_r;
    assign test_strobe_o = strobe_r;
    assign strobe_outer_cur_o = outer_r; // RULE_04
    assign strobe_center_cur_o = center_r; // RULE_04
    assign power_stage_off_o = pstage_off_r;
    assign worst_sink_o = worst_r;
    assign down_mode_o = down_r;
    assign led_level_o = lvl_r;
    assign led_current_ua_o = cur_r;
    assign ramp_tick_o = tick_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // strobe length counter; a long repetition would be too slow to check
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            strb_len_r <= '0;
        end else begin
            strb_len_r <= strobe_r ? strb_len_r + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_start;
        cal_start_i;
    endsequence
    sequence s_cal_low;
        cal_code_r == fpcc_pkg::OV_MIN && !flag_r;
    endsequence

    a_start_low_code: assert property (s_start |=> s_cal_low) // RULE_02
        else $error("calibration did not start at lowest code");
    a_flag_clear_only: assert property ($fell(flag_r) |-> $past(cal_start_i)) // RULE_08
        else $error("flag cleared without a start");
    a_done_sets_flag: assert property (st_r == fpcc_pkg::FPCC_EVAL && all_ok
        && !cal_start_i |=> flag_r && cal_code_r == $past(cal_code_r)) // RULE_07
        else $error("completion did not set flag with held code");
    a_step_one_up: assert property (st_r == fpcc_pkg::FPCC_EVAL && !all_ok && !at_top
        && !cal_start_i |=> cal_code_r == $past(cal_code_r) + 4'h1) // RULE_19
        else $error("sweep did not advance one code");
    a_hc_stage_off: assert property (strobe_r |-> power_stage_off_o
        == $past(high_current_select_i)) // RULE_05
        else $error("power stage state wrong during strobe");
    a_strobe_len: assert property ($fell(strobe_r) && !$past(cal_start_i) // RULE_04
        |-> strb_len_r == TMR_W'(fpcc_pkg::STROBE_CYC))
        else $error("test strobe length wrong");
    a_down_enter: assert property (vreg && vin_ge_vout_i |=> down_r) // RULE_10
        else $error("down mode not entered");
    a_down_exit: assert property (vreg && !vin_ge_vout_i && vin_below_vout_200_i
        |=> !down_r) // RULE_11
        else $error("down mode not left");
    a_no_lower_vin: assert property (hold_down |=> vout_r == $past(vout_r)) // RULE_13
        else $error("output lowered below input");
    a_ramp_dn_rate: assert property (ramp_tick_o && $past(ramp_dn, 2) |-> rtmr_r == '0
        ##1 (!ramp_tick_o)[*8]) // RULE_15
        else $error("ramp down stepped too fast");
    a_flag_shows_res: assert property (flag_r |-> output_voltage_code_o
        == cal_code_r) // RULE_08
        else $error("flag set but code not result");
endmodule // fpcc_ctrl

// ===== rtl/fpcc_pkg.sv
// Purpose: constants for the flash precharge calibration control block
// Assumes: 100 MHz mclk_i, all inputs synchronous
// Notes: times in ns, cycle counts derived from the clock rate
// Contract
// [RULE_01] host starts calibration by pulse; preferably shutdown, no force, no torch pin
// [RULE_02] calibration first sets output voltage to the lowest code
// [RULE_03] only enabled sinks are checked; the largest forward voltage is tracked as worst
// [RULE_04] sweep steps voltage and fires one test strobe with calibration currents
// [RULE_05] direct mode strobes from battery; high current turns power stage off
// [RULE_06] sweep stops at first step where every enabled sink has headroom
// [RULE_07] reached code is stored as result and the calibration flag is set
// [RULE_08] flag clears only at calibration start; flag set shows last result
// [RULE_09] host raises precharge before next capture when headroom was critical
// [RULE_10] in voltage mode enter down-conversion when input reaches output
// [RULE_11] leave down-conversion when input falls about 200 mV below output
// [RULE_12] host keeps regulated output at or below about 5.3 V
// [RULE_13] output is lowered no further than the input supply level
// [RULE_14] ramp up 25 mA per 12 us direct, 56.25 mA per 0.5 us high current
// [RULE_15] ramp down one step per 0.5 us, same step size as ramp up
// [RULE_16] high current setting is 2.25 times the direct drive value
// [RULE_17] enabled but open sink drives loop to high gain, may trip overvoltage
// [RULE_18] host clears enables of unused sinks
// [RULE_19] sweep rises one code per step, evaluates after each strobe ends
package fpcc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int OV_W = 4;
    localparam logic [3:0] OV_MIN = 4'h0;
    localparam logic [3:0] OV_MAX = 4'hf;
    localparam logic [3:0] OV_RST = 4'h0;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_VREG = 2'h3;
    localparam int SENSE_W = 10;
    // headroom threshold in mV, sense inputs are in mV
    localparam logic [9:0] HEADROOM_MV = 10'h190;
    localparam int SETTLE_NS = 20000;
    localparam int STROBE_NS = 10000;
    localparam int RAMP_UP_DD_NS = 12000;
    localparam int RAMP_UP_HC_NS = 500;
    localparam int RAMP_DN_NS = 500;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ) / 1000;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ) / 1000;
    localparam int RAMP_UP_DD_CYC = (RAMP_UP_DD_NS * CLK_MHZ) / 1000;
    localparam int RAMP_UP_HC_CYC = (RAMP_UP_HC_NS * CLK_MHZ) / 1000;
    localparam int RAMP_DN_CYC = (RAMP_DN_NS * CLK_MHZ) / 1000;
    localparam int TMR_W = 12;
    // step sizes in uA; the ratio 56250/25000 is the 2.25 scaling
    localparam logic [15:0] STEP_DD_UA = 16'h61a8;
    localparam logic [15:0] STEP_HC_UA = 16'hdbba;
    typedef enum logic [3:0] {
        FPCC_IDLE = 4'b0001,
        FPCC_SETTLE = 4'b0010,
        FPCC_STROBE = 4'b0100,
        FPCC_EVAL = 4'b1000
    } fpcc_cal_e;
endpackage
